// [design/flag_ops_pkg.sv]
// Package with opcodes, flag positions, register offsets and reset values.
package flag_ops_pkg;

  // ********************************************************************
  // Widths and reset values
  // ********************************************************************
  localparam int          DATA_W       = 8;
  localparam int          BIT_SEL_W    = 3;
  localparam int          REG_IDX_W    = 5;
  localparam int          REG_COUNT    = 32;
  localparam logic [7:0]  STATUS_RST   = 8'h00;
  localparam logic [7:0]  REGFILE_RST  = 8'h00;

  // ********************************************************************
  // Flag positions inside the status register
  // ********************************************************************
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // ********************************************************************
  // Operation codes
  // ********************************************************************
  typedef enum logic [4:0] {
    nop_op                    = 5'h00,
    set_carry_op              = 5'h01,
    clear_carry_op            = 5'h02,
    set_negative_op           = 5'h03,
    clear_negative_op         = 5'h04,
    set_zero_op               = 5'h05,
    clear_zero_op             = 5'h06,
    global_irq_enable_op      = 5'h07,
    global_irq_disable_op     = 5'h08,
    set_signed_op             = 5'h09,
    clear_signed_op           = 5'h0a,
    set_overflow_op           = 5'h0b,
    clear_overflow_op         = 5'h0c,
    set_transfer_op           = 5'h0d,
    clear_transfer_op         = 5'h0e,
    set_half_carry_op         = 5'h0f,
    clear_half_carry_op       = 5'h10,
    bit_load_from_transfer_op = 5'h11,
    bit_store_to_transfer_op  = 5'h12
  } flag_op_t;

  // ********************************************************************
  // APB register map and instruction register fields
  // ********************************************************************
  localparam logic [7:0] ADDR_INSTR    = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_REG_SEL  = 8'h08;
  localparam logic [7:0] ADDR_REG_DATA = 8'h0c;
  localparam int         INSTR_OP_LSB  = 0;
  localparam int         INSTR_REG_LSB = 8;
  localparam int         INSTR_BIT_LSB = 16;

  // APB slave states, one-hot.
  typedef enum logic [1:0] {
    APB_IDLE   = 2'b01,
    APB_ACCESS = 2'b10
  } apb_state_t;

endpackage : flag_ops_pkg

// [design/flag_exec.sv]
// Combinational execution of one status-flag or bit-transfer operation.
`timescale 1ns/1ps

module flag_exec (
  input  wire flag_ops_pkg::flag_op_t i_op,
  input  wire logic [7:0]             i_status,
  input  wire logic [7:0]             i_reg_val,
  input  wire logic [2:0]             i_bit,
  output logic      [7:0]             o_status,
  output logic      [7:0]             o_reg_val,
  output logic                        o_reg_we
);

  // One-hot mask of a bit position, used for flags and register bits.
  function automatic logic [7:0] bit_mask(input int pos);
    bit_mask = 8'h01 << pos;
  endfunction : bit_mask

  // Read-modify-write: only the target bit of the status or register value moves.
  function automatic logic [7:0] put_flag(input logic [7:0] s,
                                          input int pos,
                                          input logic v);
    put_flag = v ? (s | bit_mask(pos)) : (s & ~bit_mask(pos));
  endfunction : put_flag

  always_comb begin
    o_status  = i_status;
    o_reg_val = i_reg_val;
    o_reg_we  = 1'b0;
    case (i_op)
      flag_ops_pkg::set_carry_op: begin
        o_status = put_flag(i_status, flag_ops_pkg::FLAG_C, 1'b1);
      end
      flag_ops_pkg::clear_carry_op: begin
        o_status = put_flag(i_status, flag_ops_pkg::FLAG_C, 1'b0);
      end
      flag_ops_pkg::set_negative_op: begin
        o_status = put_flag(i_status, flag_ops_pkg::FLAG_N, 1'b1);
      end
      flag_ops_pkg::clear_negative_op: begin
        o_status = put_flag(i_status, flag_ops_pkg::FLAG_N, 1'b0);
      end
      flag_ops_pkg::set_zero_op: begin
        o_status = put_flag(i_status, flag_ops_pkg::FLAG_Z, 1'b1);
      end
      flag_ops_pkg::clear_zero_op: begin
        o_status = put_flag(i_status, flag_ops_pkg::FLAG_Z, 1'b0);
      end
      flag_ops_pkg::global_irq_enable_op: begin
        o_status = put_flag(i_status, flag_ops_pkg::FLAG_I, 1'b1);
      end
      flag_ops_pkg::global_irq_disable_op: begin
        o_status = put_flag(i_status, flag_ops_pkg::FLAG_I, 1'b0);
      end
      flag_ops_pkg::set_signed_op: begin
        o_status = put_flag(i_status, flag_ops_pkg::FLAG_S, 1'b1);
      end
      flag_ops_pkg::clear_signed_op: begin
        o_status = put_flag(i_status, flag_ops_pkg::FLAG_S, 1'b0);
      end
      flag_ops_pkg::set_overflow_op: begin
        o_status = put_flag(i_status, flag_ops_pkg::FLAG_V, 1'b1);
      end
      flag_ops_pkg::clear_overflow_op: begin
        o_status = put_flag(i_status, flag_ops_pkg::FLAG_V, 1'b0);
      end
      flag_ops_pkg::set_transfer_op: begin
        o_status = put_flag(i_status, flag_ops_pkg::FLAG_T, 1'b1);
      end
      flag_ops_pkg::clear_transfer_op: begin
        o_status = put_flag(i_status, flag_ops_pkg::FLAG_T, 1'b0);
      end
      flag_ops_pkg::set_half_carry_op: begin
        o_status = put_flag(i_status, flag_ops_pkg::FLAG_H, 1'b1);
      end
      flag_ops_pkg::clear_half_carry_op: begin
        o_status = put_flag(i_status, flag_ops_pkg::FLAG_H, 1'b0);
      end
      flag_ops_pkg::bit_load_from_transfer_op: begin
        o_reg_val = put_flag(i_reg_val, int'(i_bit),
                             i_status[flag_ops_pkg::FLAG_T]);
        o_reg_we  = 1'b1;
      end
      flag_ops_pkg::bit_store_to_transfer_op: begin
        o_status = put_flag(i_status, flag_ops_pkg::FLAG_T,
                            i_reg_val[i_bit]);
      end
      default: begin
        o_status = i_status;
      end
    endcase
  end

endmodule : flag_exec

// [design/status_flag_set_clear_ops.sv]
// Status-flag instruction execution with register file and APB access.
// Function
// - Bit load copies transfer flag into bit b of register d only.
// - Set/clear carry drives carry to 1/0 in one cycle, nothing else.
// - Set/clear negative drives negative flag to 1/0 in one cycle.
// - Set/clear zero drives zero flag to 1/0 in one cycle.
// - Interrupt enable/disable sets/clears interrupt flag in one cycle.
// - Set/clear signed drives signed test flag to 1/0 in one cycle.
// - Set/clear overflow drives overflow flag to 1/0 in one cycle.
// - Set/clear transfer drives transfer flag to 1/0 in one cycle.
// - Set/clear half-carry drives half-carry flag to 1/0 in one cycle.
// - Bit store copies bit b of register r into transfer flag.
`timescale 1ns/1ps

module status_flag_set_clear_ops #(
  parameter int REG_COUNT = flag_ops_pkg::REG_COUNT
) (
  input  wire logic                         i_sys_clk,
  input  wire logic                         i_rst_b,
  input  wire logic                         i_op_valid,
  input  wire flag_ops_pkg::flag_op_t       i_op_code,
  input  wire logic [flag_ops_pkg::REG_IDX_W-1:0] i_op_reg,
  input  wire logic [2:0]                   i_op_bit,
  input  wire logic                         i_psel,
  input  wire logic                         i_penable,
  input  wire logic                         i_pwrite,
  input  wire logic [31:0]                  i_paddr,
  input  wire logic [31:0]                  i_pwdata,
  output logic      [31:0]                  o_prdata,
  output logic                              o_pready,
  output logic                              o_pslverr,
  output logic      [7:0]                   o_status,
  output logic                              o_op_done
);

  // ********************************************************************
  // State
  // ********************************************************************
  logic [7:0]                     status_q;
  logic [7:0]                     regs_q [REG_COUNT];
  logic [flag_ops_pkg::REG_IDX_W-1:0] reg_sel_q;
  logic                           pend_q;
  flag_ops_pkg::flag_op_t         pend_op_q;
  logic [flag_ops_pkg::REG_IDX_W-1:0] pend_reg_q;
  logic [2:0]                     pend_bit_q;
  flag_ops_pkg::apb_state_t       apb_q;

  // ********************************************************************
  // APB decode
  // ********************************************************************
  logic                           apb_done;
  logic                           apb_wr;
  logic [7:0]                     offs;
  logic                           mapped;

  assign apb_done = i_psel && i_penable && o_pready;
  assign apb_wr   = apb_done && i_pwrite && mapped;
  assign offs     = i_paddr[7:0];
  assign mapped   = (i_paddr[31:8] == 24'h000000) &&
                    (offs == flag_ops_pkg::ADDR_INSTR ||
                     offs == flag_ops_pkg::ADDR_STATUS ||
                     offs == flag_ops_pkg::ADDR_REG_SEL ||
                     offs == flag_ops_pkg::ADDR_REG_DATA);

  // ********************************************************************
  // Operation select and execution
  // ********************************************************************
  // The decoder port has priority; an op issued over APB waits for a gap.
  logic                           run;
  flag_ops_pkg::flag_op_t         run_op;
  logic [flag_ops_pkg::REG_IDX_W-1:0] run_reg;
  logic [2:0]                     run_bit;
  logic [7:0]                     base_status;
  logic [7:0]                     new_status;
  logic [7:0]                     new_reg;
  logic                           reg_we;

  assign run     = i_op_valid || pend_q;
  assign run_op  = i_op_valid ? i_op_code : pend_op_q;
  assign run_reg = i_op_valid ? i_op_reg : pend_reg_q;
  assign run_bit = i_op_valid ? i_op_bit : pend_bit_q;

  // A same-cycle software write to the status is the base the op modifies.
  assign base_status = (apb_wr && offs == flag_ops_pkg::ADDR_STATUS) ?
                       i_pwdata[7:0] : status_q;

  flag_exec u_exec (
    .i_op      (run ? run_op : flag_ops_pkg::nop_op),
    .i_status  (base_status),
    .i_reg_val (regs_q[run_reg]),
    .i_bit     (run_bit),
    .o_status  (new_status),
    .o_reg_val (new_reg),
    .o_reg_we  (reg_we)
  );

  // Every flag operation completes in the single edge it is presented at.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      status_q <= flag_ops_pkg::STATUS_RST;
    end else begin
      status_q <= new_status;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_q[i] <= flag_ops_pkg::REGFILE_RST;
      end
    end else begin
      if (apb_wr && offs == flag_ops_pkg::ADDR_REG_DATA) begin
        regs_q[reg_sel_q] <= i_pwdata[7:0];
      end
      // The op's write comes last so it wins a collision on one register.
      if (run && reg_we) begin
        regs_q[run_reg] <= new_reg;
      end
    end
  end

  // ********************************************************************
  // Pending op from the APB instruction register
  // ********************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      pend_q     <= 1'b0;
      pend_op_q  <= flag_ops_pkg::nop_op;
      pend_reg_q <= '0;
      pend_bit_q <= '0;
    end else if (apb_wr && offs == flag_ops_pkg::ADDR_INSTR) begin
      pend_q     <= 1'b1;
      pend_op_q  <= flag_ops_pkg::flag_op_t'(
                      i_pwdata[flag_ops_pkg::INSTR_OP_LSB +: 5]);
      pend_reg_q <= i_pwdata[flag_ops_pkg::INSTR_REG_LSB +:
                             flag_ops_pkg::REG_IDX_W];
      pend_bit_q <= i_pwdata[flag_ops_pkg::INSTR_BIT_LSB +: 3];
    end else if (!i_op_valid) begin
      pend_q     <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      reg_sel_q <= '0;
    end else if (apb_wr && offs == flag_ops_pkg::ADDR_REG_SEL) begin
      reg_sel_q <= i_pwdata[flag_ops_pkg::REG_IDX_W-1:0];
    end
  end

  // ********************************************************************
  // APB handshake and read data
  // ********************************************************************
  // No wait state: pready and prdata are registered in the setup phase, so the access phase completes at once.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      apb_q     <= flag_ops_pkg::APB_IDLE;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= '0;
    end else begin
      case (apb_q)
        flag_ops_pkg::APB_IDLE: begin
          o_pready  <= 1'b0;
          o_pslverr <= 1'b0;
          if (i_psel && !i_penable) begin
            apb_q     <= flag_ops_pkg::APB_ACCESS;
            o_pready  <= 1'b1;
            o_pslverr <= !mapped;
            o_prdata  <= '0;
            if (!i_pwrite && offs == flag_ops_pkg::ADDR_STATUS) begin
              o_prdata <= {24'h000000, status_q};
            end else if (!i_pwrite && offs == flag_ops_pkg::ADDR_REG_SEL) begin
              o_prdata <= {27'h0000000, reg_sel_q};
            end else if (!i_pwrite &&
                         offs == flag_ops_pkg::ADDR_REG_DATA) begin
              o_prdata <= {24'h000000, regs_q[reg_sel_q]};
            end else if (!i_pwrite && offs == flag_ops_pkg::ADDR_INSTR) begin
              o_prdata <= {31'h00000000, pend_q};
            end
          end
        end
        flag_ops_pkg::APB_ACCESS: begin
          apb_q     <= flag_ops_pkg::APB_IDLE;
          o_pready  <= 1'b0;
          o_pslverr <= 1'b0;
        end
        default: begin
          apb_q    <= flag_ops_pkg::APB_IDLE;
          o_pready <= 1'b0;
        end
      endcase
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_status  <= flag_ops_pkg::STATUS_RST;
      o_op_done <= 1'b0;
    end else begin
      o_status  <= new_status;
      o_op_done <= run;
    end
  end

endmodule : status_flag_set_clear_ops

// [tb/flag_ops_checker.sv]
// Port-level checker for the status-flag operation block.
`timescale 1ns/1ps

module flag_ops_checker (
  input wire logic                   i_sys_clk,
  input wire logic                   i_rst_b,
  input wire logic                   i_op_valid,
  input wire flag_ops_pkg::flag_op_t i_op_code,
  input wire logic                   i_psel,
  input wire logic                   i_penable,
  input wire logic                   i_pwrite,
  input wire logic                   o_pready,
  input wire logic                   o_pslverr,
  input wire logic [7:0]             o_status,
  input wire logic                   o_op_done
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  // A register write in the same cycle may legally rewrite any flag.
  wire quiet = !(i_psel && i_penable && i_pwrite);

  sequence s_setup;
    i_psel && !i_penable;
  endsequence

  property p_flag(flag_ops_pkg::flag_op_t op_s, flag_ops_pkg::flag_op_t op_c,
                  int pos);
    i_op_valid && quiet && (i_op_code == op_s || i_op_code == op_c)
    |=> o_status == (($past(o_status) & ~(8'h01 << pos))
                    | (8'({7'h00, $past(i_op_code) == op_s}) << pos));
  endproperty

  a_carry_flag: assert property (
    p_flag(flag_ops_pkg::set_carry_op,
           flag_ops_pkg::clear_carry_op, flag_ops_pkg::FLAG_C))
    else $error("carry flag wrong");
  a_neg_flag: assert property (
    p_flag(flag_ops_pkg::set_negative_op,
           flag_ops_pkg::clear_negative_op, flag_ops_pkg::FLAG_N))
    else $error("negative flag wrong");
  a_zero_flag: assert property (
    p_flag(flag_ops_pkg::set_zero_op,
           flag_ops_pkg::clear_zero_op, flag_ops_pkg::FLAG_Z))
    else $error("zero flag wrong");
  a_irq_flag: assert property (
    p_flag(flag_ops_pkg::global_irq_enable_op,
           flag_ops_pkg::global_irq_disable_op, flag_ops_pkg::FLAG_I))
    else $error("irq flag wrong");
  a_signed_flag: assert property (
    p_flag(flag_ops_pkg::set_signed_op,
           flag_ops_pkg::clear_signed_op, flag_ops_pkg::FLAG_S))
    else $error("signed flag wrong");
  a_ovf_flag: assert property (
    p_flag(flag_ops_pkg::set_overflow_op,
           flag_ops_pkg::clear_overflow_op, flag_ops_pkg::FLAG_V))
    else $error("overflow flag wrong");
  a_xfer_flag: assert property (
    p_flag(flag_ops_pkg::set_transfer_op,
           flag_ops_pkg::clear_transfer_op, flag_ops_pkg::FLAG_T))
    else $error("transfer flag wrong");
  a_half_flag: assert property (
    p_flag(flag_ops_pkg::set_half_carry_op,
           flag_ops_pkg::clear_half_carry_op, flag_ops_pkg::FLAG_H))
    else $error("half flag wrong");
  a_op_done: assert property (i_op_valid |=> o_op_done)
    else $error("op done missing");
  a_ready_once: assert property (s_setup |=> o_pready ##1 !o_pready)
    else $error("ready not a single pulse");
  a_err_ready: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
endmodule : flag_ops_checker

bind status_flag_set_clear_ops flag_ops_checker u_chk (.i_sys_clk, .i_rst_b,
  .i_op_valid, .i_op_code, .i_psel, .i_penable, .i_pwrite, .o_pready,
  .o_pslverr, .o_status, .o_op_done);

// [tb/tb_top.sv]
// Self-checking bench for the status-flag operation block.
`timescale 1ns/1ps

module tb_top;
  logic                   i_sys_clk;
  logic                   i_rst_b;
  logic                   i_op_valid;
  flag_ops_pkg::flag_op_t i_op_code;
  logic [4:0]             i_op_reg;
  logic [2:0]             i_op_bit;
  logic                   i_psel;
  logic                   i_penable;
  logic                   i_pwrite;
  logic [31:0]            i_paddr;
  logic [31:0]            i_pwdata;
  logic [31:0]            o_prdata;
  logic                   o_pready;
  logic                   o_pslverr;
  logic [7:0]             o_status;
  logic                   o_op_done;
  logic [31:0]            rd;
  logic                   err;
  int                     n_errors;
  int                     checked;

  status_flag_set_clear_ops dut (.i_sys_clk, .i_rst_b, .i_op_valid,
    .i_op_code, .i_op_reg, .i_op_bit, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_status,
    .o_op_done);

  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end

  // ******************************************************************
  // Shared tasks
  // ******************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
    end
  endtask : check

  // The master waits on pready itself; only the watchdog ends a hang.
  task automatic apb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd);
    @(posedge i_sys_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= wd;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_sys_clk);
    end while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  task automatic op(input flag_ops_pkg::flag_op_t c, input logic [4:0] r,
                    input logic [2:0] b);
    @(posedge i_sys_clk);
    i_op_valid <= 1'b1;
    i_op_code <= c;
    i_op_reg <= r;
    i_op_bit <= b;
    @(posedge i_sys_clk);
    i_op_valid <= 1'b0;
    @(negedge i_sys_clk);
    check(32'(o_op_done), 32'h1);
  endtask : op

  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  // ******************************************************************
  // Scenarios
  // ******************************************************************
  task automatic t_flags;
    int pos[8] = '{flag_ops_pkg::FLAG_C, flag_ops_pkg::FLAG_N,
                   flag_ops_pkg::FLAG_Z, flag_ops_pkg::FLAG_I,
                   flag_ops_pkg::FLAG_S, flag_ops_pkg::FLAG_V,
                   flag_ops_pkg::FLAG_T, flag_ops_pkg::FLAG_H};
    logic [7:0] m;
    logic [7:0] base;
    for (int f = 0; f < 8; f++) begin
      m = 8'h01 << pos[f];
      for (int k = 0; k < 2; k++) begin
        base = k ? 8'h5a : 8'ha5;
        apb(1'b1, 32'h04, 32'(base));
        @(posedge i_sys_clk);
        i_op_valid <= 1'b1;
        i_op_code <= flag_ops_pkg::flag_op_t'(5'(2 * f + 1));
        @(posedge i_sys_clk);
        i_op_code <= flag_ops_pkg::flag_op_t'(5'(2 * f + 2));
        @(negedge i_sys_clk);
        check(32'(o_status), 32'(base | m));
        @(posedge i_sys_clk);
        i_op_valid <= 1'b0;
        @(negedge i_sys_clk);
        check(32'(o_status), 32'(base & ~m));
      end
    end
  endtask : t_flags

  task automatic t_bits;
    apb(1'b1, 32'h08, 32'h05);
    apb(1'b1, 32'h0c, 32'h20);
    apb(1'b1, 32'h04, 32'h00);
    op(flag_ops_pkg::bit_store_to_transfer_op, 5'h05, 3'h5);
    check(32'(o_status), 32'h40);
    op(flag_ops_pkg::bit_store_to_transfer_op, 5'h05, 3'h0);
    check(32'(o_status), 32'h00);
    apb(1'b1, 32'h08, 32'h1f);
    apb(1'b1, 32'h0c, 32'h3c);
    op(flag_ops_pkg::set_transfer_op, 5'h00, 3'h0);
    op(flag_ops_pkg::bit_load_from_transfer_op, 5'h1f, 3'h7);
    check(32'(o_status), 32'h40);
    apb(1'b0, 32'h0c, 32'h00);
    check(rd, 32'hbc);
    op(flag_ops_pkg::clear_transfer_op, 5'h00, 3'h0);
    op(flag_ops_pkg::bit_load_from_transfer_op, 5'h1f, 3'h2);
    apb(1'b0, 32'h0c, 32'h00);
    check(rd, 32'hb8);
  endtask : t_bits

  // Software-issued operations and refused addresses.
  task automatic t_apb;
    apb(1'b1, 32'h10, 32'hff);
    check(32'(err), 32'h1);
    apb(1'b0, 32'h104, 32'h00);
    check(32'(err), 32'h1);
    check(rd, 32'h00);
    apb(1'b1, 32'h04, 32'h00);
    apb(1'b1, 32'h00, 32'(flag_ops_pkg::set_half_carry_op));
    apb(1'b0, 32'h04, 32'h00);
    check(rd, 32'h20);
    op(flag_ops_pkg::nop_op, 5'h00, 3'h0);
    check(32'(o_status), 32'h20);
  endtask : t_apb

  task automatic t_reset_mid;
    @(posedge i_sys_clk);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    @(negedge i_sys_clk);
    check(32'(o_status), 32'h00);
    apb(1'b0, 32'h08, 32'h00);
    check(rd, 32'h00);
    apb(1'b1, 32'h08, 32'h1f);
    apb(1'b0, 32'h0c, 32'h00);
    check(rd, 32'h00);
  endtask : t_reset_mid

  initial begin
    n_errors = 0;
    checked = 0;
    i_rst_b = 1'b0;
    i_op_valid = 1'b0;
    i_op_code = flag_ops_pkg::nop_op;
    i_op_reg = 5'h00;
    i_op_bit = 3'h0;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 32'h0;
    i_pwdata = 32'h0;
    repeat (12) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    apb(1'b0, 32'h04, 32'h00);
    check(rd, 32'h00);
    t_flags;
    t_bits;
    t_apb;
    t_reset_mid;
    end_sim;
  end

  initial begin
    #400000;
    n_errors++;
    end_sim;
  end
endmodule : tb_top
